// ===== rtl/ast_async_serial_unit.sv
// Full-duplex asynchronous serial transceiver with APB register slave
`include "ast_defs.svh"
module ast_async_serial_unit
   import ast_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        serial_in_pin,
   output logic             tx_pin_out,
   output logic             tx_pin_oe_out
);
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   // Oversample divider: prescaler times power of two
   function automatic logic [10:0] baud_div(input logic [1:0] pr, input logic [2:0] ex);
      logic [10:0] p;
      p = (pr == 2'd0) ? 11'd1 : (pr == 2'd1) ? 11'd3 : (pr == 2'd2) ? 11'd4 : 11'd13;
      baud_div = p << ex;
   endfunction : baud_div

   // Majority of three samples
   function automatic logic maj3(input logic [2:0] s);
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction : maj3

   // ---------------------------------------------
   // Register bus
   // ---------------------------------------------
   logic [7:0]  ctrl1_q, ctrl1_d, baud_q, baud_d;
   logic [2:0]  ctrl2_q, ctrl2_d;   // te, re, sbk
   logic        arm_q, arm_d, pready_q, pready_d, perr_q, perr_d;
   logic [31:0] prdata_q, prdata_d;
   logic        acc, wr_data, rd_data, wr_c2;
   logic [7:0]  status, rdr_q, rdr_d;
   logic        rwu_q, rwu_d, r8_q, r8_d;
   logic        mode9, txen, re, sbk;

   assign acc     = psel_in & penable_in & pready_q;
   assign wr_data = acc & pwrite_in & (paddr_in == `AST_OFS_DATA);
   assign rd_data = acc & ~pwrite_in & (paddr_in == `AST_OFS_DATA);
   assign wr_c2   = acc & pwrite_in & (paddr_in == `AST_OFS_CTRL2);
   assign mode9   = ctrl1_q[`AST_C1_M];
   assign txen    = ctrl2_q[2];
   assign re      = ctrl2_q[1];
   assign sbk     = ctrl2_q[0];

   // Setup cycle prepares read data; access completes one cycle later
   always_comb begin
      ctrl1_d  = ctrl1_q;
      ctrl2_d  = ctrl2_q;
      baud_d   = baud_q;
      arm_d    = arm_q;
      prdata_d = prdata_q;
      pready_d = psel_in & ~penable_in;
      perr_d   = 1'b0;
      if (psel_in & ~penable_in) begin
         prdata_d = 32'h0000_0000;
         if (paddr_in == `AST_OFS_STATUS) begin
            prdata_d[7:0] = status;
         end else if (paddr_in == `AST_OFS_DATA) begin
            prdata_d[7:0] = rdr_q;
         end else if (paddr_in == `AST_OFS_CTRL1) begin
            prdata_d[7:0] = {r8_q, ctrl1_q[6:0]};
         end else if (paddr_in == `AST_OFS_CTRL2) begin
            prdata_d[3:0] = {ctrl2_q[2:1], rwu_q, ctrl2_q[0]};
         end else if (paddr_in == `AST_OFS_BAUD) begin
            prdata_d[7:0] = baud_q;
         end else begin
            perr_d = 1'b1;  // Unmapped address answers with an error
         end
      end
      if (acc & pwrite_in) begin
         if (paddr_in == `AST_OFS_CTRL1) begin
            ctrl1_d = {1'b0, pwdata_in[6:0]};
         end else if (paddr_in == `AST_OFS_CTRL2) begin
            ctrl2_d = {pwdata_in[`AST_C2_TXEN], pwdata_in[`AST_C2_RE], pwdata_in[`AST_C2_SBK]};
         end else if (paddr_in == `AST_OFS_BAUD) begin
            baud_d = pwdata_in[7:0];
         end
      end
      // A status read arms the clear; the next data access uses it up
      if (acc & ~pwrite_in & (paddr_in == `AST_OFS_STATUS)) begin
         arm_d = 1'b1;
      end else if (wr_data | rd_data) begin
         arm_d = 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ctrl1_q  <= `AST_RST_ZERO;
         ctrl2_q  <= 3'b000;
         baud_q   <= `AST_RST_ZERO;
         arm_q    <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         perr_q   <= 1'b0;
      end else begin
         ctrl1_q  <= ctrl1_d;
         ctrl2_q  <= ctrl2_d;
         baud_q   <= baud_d;
         arm_q    <= arm_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         perr_q   <= perr_d;
      end
   end
   assign prdata_out  = prdata_q;
   assign pready_out  = pready_q;
   assign pslverr_out = perr_q;

   // ---------------------------------------------
   // Baud generators, one per direction
   // ---------------------------------------------
   logic [10:0] bcnt_q [2];
   logic [1:0]  tick;
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_baud
         logic [10:0] div, bcnt_d;
         assign div = baud_div(baud_q[7:6], (g == 0) ? baud_q[5:3] : baud_q[2:0]);
         always_comb begin
            bcnt_d = (bcnt_q[g] + 11'd1 >= div) ? 11'd0 : bcnt_q[g] + 11'd1;
         end
         always_ff @(posedge clk_in) begin
            if (reset_in) begin
               bcnt_q[g] <= 11'd0;
            end else begin
               bcnt_q[g] <= bcnt_d;
            end
         end
         assign tick[g] = (bcnt_q[g] == 11'd0);
      end
   endgenerate

   // ---------------------------------------------
   // Transmitter
   // ---------------------------------------------
   ast_tx_t     txs_q, txs_d;
   logic [10:0] tsr_q, tsr_d;
   logic [3:0]  tph_q, tph_d, tbits_q, tbits_d;
   logic [8:0]  thold_q, thold_d, tword;
   logic        tfull_q, tfull_d, tempty_q, tempty_d, tdone_q, tdone_d;
   logic        idreq_q, idreq_d, txen_q, brk_q, brk_d, tail_q, tail_d, tdat_q, tdat_d;
   logic        pin_q, pin_d, oe_q, oe_d, tend;
   logic [3:0]  flen;

   assign flen = mode9 ? 4'd11 : 4'd10;
   assign tend = (txs_q == AST_TX_SEND) & tick[0] & (tph_q == `AST_OVERSAMPLE);

   // Word with ninth bit or parity in the MSB place
   always_comb begin
      tword = mode9 ? {ctrl1_q[`AST_C1_TXB8], thold_q[7:0]} : {1'b0, thold_q[7:0]};
      if (ctrl1_q[`AST_C1_PCE]) begin
         if (mode9) begin
            tword[8] = ^thold_q[7:0] ^ ctrl1_q[`AST_C1_PS];
         end else begin
            tword[7] = ^thold_q[6:0] ^ ctrl1_q[`AST_C1_PS];
         end
      end
   end

   // Frame sequencer: idle, break, break tail and data frames
   always_comb begin
      txs_d   = txs_q;
      tsr_d   = tsr_q;
      tph_d   = tph_q;
      tbits_d = tbits_q;
      thold_d  = thold_q;
      tfull_d  = tfull_q;
      tempty_d = tempty_q;
      tdone_d  = tdone_q;
      idreq_d  = idreq_q | (txen & ~txen_q);
      brk_d    = brk_q;
      tail_d   = tail_q;
      tdat_d   = tdat_q;
      if (wr_data & arm_q) begin
         tempty_d = 1'b0;
         tdone_d  = 1'b0;
      end
      if (wr_data) begin
         thold_d = {1'b0, pwdata_in[7:0]};
         tfull_d = 1'b1;
      end
      case (txs_q)
         AST_TX_HOLD: begin
            tph_d = 4'd0;
            if (txen & idreq_q) begin
               tsr_d   = 11'h7FF;
               tbits_d = flen;
               idreq_d = 1'b0;
               brk_d   = 1'b0;
               tdat_d  = 1'b0;
               txs_d   = AST_TX_SEND;
            end else if (txen & sbk) begin
               tsr_d   = 11'h000;
               tbits_d = flen;
               brk_d   = 1'b1;
               tail_d  = 1'b1;
               tdat_d  = 1'b0;
               txs_d   = AST_TX_SEND;
            end else if (txen & tail_q) begin
               tsr_d   = 11'h7FF;
               tbits_d = 4'd1;
               tail_d  = 1'b0;
               brk_d   = 1'b0;
               tdat_d  = 1'b0;
               txs_d   = AST_TX_SEND;
            end else if (txen & tfull_q) begin
               tsr_d   = mode9 ? {1'b1, tword, 1'b0} : {2'b11, tword[7:0], 1'b0};
               tbits_d = flen;
               tfull_d = wr_data;
               tempty_d = 1'b1;
               brk_d   = 1'b0;
               tdat_d  = 1'b1;
               txs_d   = AST_TX_SEND;
            end
         end
         AST_TX_SEND: begin
            if (tick[0]) begin
               tph_d = tph_q + 4'd1;
            end
            if (tend) begin
               tsr_d   = {1'b1, tsr_q[10:1]};
               tbits_d = tbits_q - 4'd1;
               if (tbits_q == 4'd1) begin
                  txs_d = AST_TX_HOLD;
                  if (tdat_q | brk_q) begin
                     tdone_d = 1'b1;
                  end
               end
            end
         end
         default: txs_d = AST_TX_HOLD;
      endcase
      // Pin stays high between frames, released when both sides are off
      pin_d = (txs_q == AST_TX_SEND) ? tsr_q[0] : 1'b1;
      oe_d  = txen | re;
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         txs_q   <= AST_TX_HOLD;
         tsr_q   <= 11'h7FF;
         tph_q   <= 4'd0;
         tbits_q <= 4'd0;
         thold_q  <= 9'd0;
         tfull_q  <= 1'b0;
         tempty_q <= 1'b1;
         tdone_q  <= 1'b1;
         idreq_q  <= 1'b0;
         txen_q   <= 1'b0;
         brk_q   <= 1'b0;
         tail_q  <= 1'b0;
         tdat_q  <= 1'b0;
         pin_q   <= 1'b1;
         oe_q    <= 1'b0;
      end else begin
         txs_q   <= txs_d;
         tsr_q   <= tsr_d;
         tph_q   <= tph_d;
         tbits_q <= tbits_d;
         thold_q  <= thold_d;
         tfull_q  <= tfull_d;
         tempty_q <= tempty_d;
         tdone_q  <= tdone_d;
         idreq_q  <= idreq_d;
         txen_q   <= txen;
         brk_q   <= brk_d;
         tail_q  <= tail_d;
         tdat_q  <= tdat_d;
         pin_q   <= pin_d;
         oe_q    <= oe_d;
      end
   end
   assign tx_pin_out    = pin_q;
   assign tx_pin_oe_out = oe_q;

   // ---------------------------------------------
   // Receiver
   // ---------------------------------------------
   ast_rx_t     rxs_q, rxs_d;
   logic        rs1_q, rs2_q, rs3_q;
   logic [3:0]  rph_q, rph_d, ridx_q, ridx_d;
   logic [2:0]  smp_q, smp_d;
   logic [9:0]  rsr_q, rsr_d;
   logic [7:0]  icnt_q, icnt_d;
   logic        rbit, rnoise, nacc_q, nacc_d, iarm_q, iarm_d;
   logic [5:0]  fl_q, fl_d;   // rx full, idle, overrun, noise, framing, parity
   logic [8:0]  rword;
   logic        perr;
   logic        rdone;

   // Samples 8, 9 and 10 of each bit decide it
   assign rbit   = maj3(smp_q);
   assign rnoise = ~(&smp_q) & (|smp_q);
   assign rword  = mode9 ? rsr_d[8:0] : {1'b0, rsr_d[8:1]};
   assign perr   = ctrl1_q[`AST_C1_PCE] & ((^rword) ^ ctrl1_q[`AST_C1_PS]);
   assign status = {tempty_q, tdone_q, fl_q};
   // Stop bit ends once its samples are in, so a start bit right behind it is not missed
   assign rdone  = (ridx_q == flen - 4'd1) ? (rph_q == `AST_SMP_C + 4'd1) : (rph_q == `AST_OVERSAMPLE);

   always_comb begin
      rxs_d  = rxs_q;
      rph_d  = rph_q;
      ridx_d = ridx_q;
      smp_d  = smp_q;
      rsr_d  = rsr_q;
      icnt_d = icnt_q;
      nacc_d = nacc_q;
      iarm_d = iarm_q;
      rdr_d  = rdr_q;
      r8_d   = r8_q;
      rwu_d  = rwu_q;
      fl_d   = fl_q;
      if (rd_data & arm_q) begin
         fl_d = 6'd0;
      end
      case (rxs_q)
         AST_RX_HUNT: begin
            rph_d = 4'd0;
            if (re & rs3_q & ~rs2_q) begin
               rxs_d  = AST_RX_BITS;
               ridx_d = 4'd0;
               icnt_d = 8'd0;
            end else if (~rs2_q) begin
               icnt_d = 8'd0;
            end else if (re & tick[1]) begin
               icnt_d = icnt_q + 8'd1;
               if (icnt_q == {flen, 4'h0} - 8'd1) begin
                  icnt_d = 8'd0;
                  if (iarm_q) begin
                     iarm_d = 1'b0;
                     if (rwu_q) begin
                        rwu_d = ctrl1_q[`AST_C1_WAKE];
                     end else begin
                        fl_d[4] = 1'b1;
                     end
                  end
               end
            end
         end
         AST_RX_BITS: begin
            if (tick[1]) begin
               rph_d = rph_q + 4'd1;
               if (rph_q == `AST_SMP_A || rph_q == `AST_SMP_B || rph_q == `AST_SMP_C) begin
                  smp_d = {smp_q[1:0], rs2_q};
               end
               if (rdone) begin
                  nacc_d = nacc_q | rnoise;
                  ridx_d = ridx_q + 4'd1;
                  if (ridx_q == 4'd0) begin
                     if (rbit) begin
                        rxs_d = AST_RX_HUNT;  // False start
                     end
                  end else begin
                     rsr_d = {rbit, rsr_q[9:1]};
                     if (ridx_q == flen - 4'd1) begin
                        rxs_d  = AST_RX_HUNT;
                        iarm_d = 1'b1;
                        nacc_d = 1'b0;
                        if (rwu_q & ~(ctrl1_q[`AST_C1_WAKE] & (mode9 ? rword[8] : rword[7]))) begin
                           nacc_d = nacc_q | rnoise;  // Muted: no status changes
                        end else if (fl_q[5]) begin
                           rwu_d   = 1'b0;
                           fl_d[3] = 1'b1;
                        end else begin
                           rwu_d   = 1'b0;
                           rdr_d   = rword[7:0];
                           r8_d    = rword[8];
                           fl_d[5] = 1'b1;
                           fl_d[2] = nacc_q | rnoise;
                           fl_d[1] = ~rbit;
                           fl_d[0] = perr;
                        end
                     end
                  end
               end
            end
         end
         default: rxs_d = AST_RX_HUNT;
      endcase
      if (~re) begin
         rxs_d = AST_RX_HUNT;
      end
      if (wr_c2) begin
         rwu_d = pwdata_in[`AST_C2_RWU];
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rs1_q  <= 1'b1;
         rs2_q  <= 1'b1;
         rs3_q  <= 1'b1;
         rxs_q  <= AST_RX_HUNT;
         rph_q  <= 4'd0;
         ridx_q <= 4'd0;
         smp_q  <= 3'b111;
         rsr_q  <= 10'd0;
         icnt_q <= 8'd0;
         nacc_q <= 1'b0;
         iarm_q <= 1'b0;
         rdr_q  <= `AST_RST_ZERO;
         r8_q   <= 1'b0;
         rwu_q  <= 1'b0;
         fl_q   <= 6'd0;
      end else begin
         rs1_q  <= serial_in_pin;
         rs2_q  <= rs1_q;
         rs3_q  <= rs2_q;
         rxs_q  <= rxs_d;
         rph_q  <= rph_d;
         ridx_q <= ridx_d;
         smp_q  <= smp_d;
         rsr_q  <= rsr_d;
         icnt_q <= icnt_d;
         nacc_q <= nacc_d;
         iarm_q <= iarm_d;
         rdr_q  <= rdr_d;
         r8_q   <= r8_d;
         rwu_q  <= rwu_d;
         fl_q   <= fl_d;
      end
   end

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   property p_release;
      @(posedge clk_in) disable iff (reset_in) !(txen | re) |=> !tx_pin_oe_out;
   endproperty
   a_release: assert property (p_release) else $error("pin not released");
   property p_idle_high;
      @(posedge clk_in) disable iff (reset_in) (txs_q == AST_TX_HOLD) |=> tx_pin_out;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("idle pin not high");
   property p_start_low;
      @(posedge clk_in) disable iff (reset_in)
         (txs_q == AST_TX_HOLD && txs_d == AST_TX_SEND && tdat_d) |=> ##1 !tx_pin_out;
   endproperty
   a_start_low: assert property (p_start_low) else $error("start bit not low");
   property p_stop_high;
      @(posedge clk_in) disable iff (reset_in) (tend && tbits_q == 4'd1 && tdat_q) |-> tx_pin_out;
   endproperty
   a_stop_high: assert property (p_stop_high) else $error("stop bit not high");
   property p_tc_set;
      @(posedge clk_in) disable iff (reset_in) (tend && tbits_q == 4'd1 && (tdat_q | brk_q)) |=> tdone_q;
   endproperty
   a_tc_set: assert property (p_tc_set) else $error("complete flag missed");
   property p_empty_clr;
      @(posedge clk_in) disable iff (reset_in) (wr_data && arm_q && txs_q == AST_TX_SEND) |=> !tempty_q;
   endproperty
   a_empty_clr: assert property (p_empty_clr) else $error("empty flag not cleared");
   property p_direct;
      @(posedge clk_in) disable iff (reset_in)
         (txs_q == AST_TX_HOLD && txen && !idreq_q && !sbk && !tail_q && tfull_q) |=> tempty_q && txs_q == AST_TX_SEND;
   endproperty
   a_direct: assert property (p_direct) else $error("direct load failed");
   property p_overrun;
      @(posedge clk_in) disable iff (reset_in) (fl_q[5] && fl_d[3] && !fl_q[3]) |=> rdr_q == $past(rdr_q);
   endproperty
   a_overrun: assert property (p_overrun) else $error("buffered data lost");
   property p_enable_idle;
      @(posedge clk_in) disable iff (reset_in)
         (txen && !txen_q && txs_q == AST_TX_HOLD) |=> ##1 txs_q == AST_TX_SEND && !tdat_q;
   endproperty
   a_enable_idle: assert property (p_enable_idle) else $error("no idle frame");
   c_data:   cover property (@(posedge clk_in) disable iff (reset_in) tend && tdat_q && tbits_q == 4'd1);
   c_break:  cover property (@(posedge clk_in) disable iff (reset_in) tend && brk_q && tbits_q == 4'd1);
   c_rx:     cover property (@(posedge clk_in) disable iff (reset_in) !fl_q[5] && fl_d[5]);
   c_ovr:    cover property (@(posedge clk_in) disable iff (reset_in) !fl_q[3] && fl_d[3]);
endmodule : ast_async_serial_unit

// ===== rtl/ast_defs.svh
// Register offsets, field positions, reset values and timing counts of the serial unit
`ifndef AST_DEFS_SVH
`define AST_DEFS_SVH
// ---------------------------------------------
// Register byte offsets
// ---------------------------------------------
`define AST_OFS_STATUS   8'h00
`define AST_OFS_DATA     8'h04
`define AST_OFS_CTRL1    8'h08
`define AST_OFS_CTRL2    8'h0C
`define AST_OFS_BAUD     8'h10
// ---------------------------------------------
// Field positions
// ---------------------------------------------
`define AST_ST_TXEMPTY 7
`define AST_ST_TXDONE  6
`define AST_ST_RXFULL  5
`define AST_ST_IDLE    4
`define AST_ST_OR      3
`define AST_ST_NOISE   2
`define AST_ST_FE    1
`define AST_ST_PE    0
`define AST_C1_R8    7
`define AST_C1_TXB8  6
`define AST_C1_M     4
`define AST_C1_WAKE  3
`define AST_C1_PCE   2
`define AST_C1_PS    1
`define AST_C2_TXEN  3
`define AST_C2_RE    2
`define AST_C2_RWU   1
`define AST_C2_SBK   0
// ---------------------------------------------
// Reset values and timing counts
// ---------------------------------------------
`define AST_RST_STATUS 8'hC0
`define AST_RST_ZERO   8'h00
`define AST_OVERSAMPLE 4'hF
`define AST_SMP_A      4'h7
`define AST_SMP_B      4'h8
`define AST_SMP_C      4'h9
`endif

// ===== rtl/ast_pkg.sv
// Types shared by the serial transceiver
package ast_pkg;
   typedef enum logic [1:0] {AST_TX_HOLD = 2'b01, AST_TX_SEND = 2'b10} ast_tx_t;
   typedef enum logic [1:0] {AST_RX_HUNT = 2'b01, AST_RX_BITS = 2'b10} ast_rx_t;
endpackage : ast_pkg

// ===== testbench/ast_serial_peer.sv
// Far-side serial equipment model that drives the receive line
module ast_serial_peer #(
   parameter int BIT_CYCLES = 32
) (
   input  wire logic clk_in,
   output logic      line_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Line rests high between frames, like a pulled-up wire
   initial line_out = 1'b1;
   // Start, word LSB first, stop; caller enters right after an edge
   task automatic send_word(input logic [8:0] word, input int nbits);
      line_out <= 1'b0;
      repeat (BIT_CYCLES) @(posedge clk_in);
      for (int i = 0; i < nbits; i++) begin
         line_out <= word[i];
         repeat (BIT_CYCLES) @(posedge clk_in);
      end
      line_out <= 1'b1;
      repeat (BIT_CYCLES) @(posedge clk_in);
   endtask : send_word
endmodule : ast_serial_peer

// ===== testbench/testbench.sv
// Self-checking bench for the serial transceiver
`include "ast_defs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_in = 1'b0;
   logic        reset_in = 1'b1;
   logic        psel_in = 1'b0;
   logic        penable_in = 1'b0;
   logic        pwrite_in = 1'b0;
   logic [7:0]  paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0000_0000;
   logic [31:0] prdata_out;
   logic        pready_out;
   logic        pslverr_out;
   logic        serial_line;
   logic        tx_pin_out;
   logic        tx_pin_oe_out;
   logic [31:0] rd;
   logic        err;
   logic [10:0] fr;
   int          wt;
   int          n_fail = 0;
   int          checks = 0;

   always #20 clk_in = ~clk_in;

   ast_async_serial_unit u_dut (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .serial_in_pin(serial_line), .tx_pin_out(tx_pin_out), .tx_pin_oe_out(tx_pin_oe_out));
   // Receive rate is half the transmit rate to show the two generators apart
   ast_serial_peer #(.BIT_CYCLES(32)) u_peer (.clk_in(clk_in), .line_out(serial_line));

   // ------------------------------------------------
   // Shared tasks
   // ------------------------------------------------
   task automatic end_of_test();
      if (n_fail == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic hang();
      n_fail++;
      $display("[ERR] %0t wait limit reached", $time);
      end_of_test();
   endtask : hang

   // One APB transfer; the extra edge up front keeps drives one per time step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk_in);
      psel_in   <= 1'b1;
      pwrite_in <= wr;
      paddr_in  <= a;
      pwdata_in <= wd;
      @(posedge clk_in);
      penable_in <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 16);
      if (n >= 16) hang();
      rd  = prdata_out;
      err = pslverr_out;
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
   endtask : apb

   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd & m, exp);
   endtask : rchk

   // Waits for a start bit, then samples each bit near the middle of its 16-cycle slot
   task automatic cap_tx(input int nbits);
      fr = '1;
      wt = 0;
      while (tx_pin_out !== 1'b0 && wt < 4000) begin
         @(posedge clk_in);
         wt++;
      end
      if (wt >= 4000) hang();
      repeat (6) @(posedge clk_in);
      for (int i = 0; i <= nbits + 1; i++) begin
         fr[i] = tx_pin_out;
         repeat (16) @(posedge clk_in);
      end
   endtask : cap_tx

   // ------------------------------------------------
   // Main sequence
   // ------------------------------------------------
   initial begin
      repeat (5) @(posedge clk_in);
      reset_in <= 1'b0;
      chk(tx_pin_oe_out, 1'b0);
      rchk(`AST_OFS_STATUS, 32'h0000_00FF, 32'h0000_00C0);
      rchk(`AST_OFS_CTRL2, 32'h0000_00FF, 32'h0000_0000);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk({31'h0000_0000, err}, 32'h0000_0001);
      apb(1'b1, `AST_OFS_BAUD, 32'h0000_0001);
      apb(1'b1, `AST_OFS_CTRL2, 32'h0000_000C);
      // Enable reaches the registered pin driver one cycle after the write
      repeat (2) @(posedge clk_in);
      chk({tx_pin_oe_out, tx_pin_out}, 2'b11);
      // Data written during the idle frame must wait in the holding buffer
      rchk(`AST_OFS_STATUS, 32'h0000_0080, 32'h0000_0080);
      apb(1'b1, `AST_OFS_DATA, 32'h0000_00A5);
      rchk(`AST_OFS_STATUS, 32'h0000_0080, 32'h0000_0000);
      cap_tx(8);
      chk(wt >= 140, 1'b1);
      chk(fr, {2'b11, 8'hA5, 1'b0});
      rchk(`AST_OFS_STATUS, 32'h0000_00C0, 32'h0000_00C0);
      // Nine-bit word while the shifter is idle
      apb(1'b1, `AST_OFS_CTRL1, 32'h0000_0050);
      rchk(`AST_OFS_STATUS, 32'h0000_00C0, 32'h0000_00C0);
      apb(1'b1, `AST_OFS_DATA, 32'h0000_003C);
      rchk(`AST_OFS_STATUS, 32'h0000_00C0, 32'h0000_0080);
      cap_tx(9);
      chk(fr, {1'b1, 1'b1, 8'h3C, 1'b0});
      // Reception at its own rate, then an overrun
      apb(1'b1, `AST_OFS_CTRL1, 32'h0000_0000);
      u_peer.send_word(9'h05A, 8);
      repeat (40) @(posedge clk_in);
      rchk(`AST_OFS_STATUS, 32'h0000_002F, 32'h0000_0020);
      rchk(`AST_OFS_DATA, 32'h0000_00FF, 32'h0000_005A);
      u_peer.send_word(9'h011, 8);
      u_peer.send_word(9'h022, 8);
      repeat (40) @(posedge clk_in);
      rchk(`AST_OFS_STATUS, 32'h0000_0028, 32'h0000_0028);
      rchk(`AST_OFS_DATA, 32'h0000_00FF, 32'h0000_0011);
      // Even parity both ways, then a received break
      apb(1'b1, `AST_OFS_CTRL1, 32'h0000_0004);
      apb(1'b1, `AST_OFS_DATA, 32'h0000_0001);
      cap_tx(8);
      chk(fr, {2'b11, 8'h81, 1'b0});
      u_peer.send_word(9'h001, 8);
      repeat (40) @(posedge clk_in);
      rchk(`AST_OFS_STATUS, 32'h0000_002F, 32'h0000_0021);
      rchk(`AST_OFS_DATA, 32'h0000_00FF, 32'h0000_0001);
      u_peer.send_word(9'h000, 9);
      repeat (40) @(posedge clk_in);
      rchk(`AST_OFS_STATUS, 32'h0000_002F, 32'h0000_0022);
      apb(1'b1, `AST_OFS_CTRL2, 32'h0000_0000);
      repeat (2) @(posedge clk_in);
      chk(tx_pin_oe_out, 1'b0);
      end_of_test();
   end
endmodule : testbench
